// ---- design/trace_counter_pkg.sv ----
// Constants, register map and packet types for the trace cycle and profiling counters
`default_nettype none
package trace_counter_pkg;
    // Register indices; byte address is four times the index
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_CYCLE = 3'h1;
    localparam logic [2:0] IDX_PROF0 = 3'h2;
    localparam logic [2:0] IDX_LAST = 3'h6;
    // Control register fields
    localparam int CTL_CC_ENA = 0;
    localparam int CTL_RELOAD_LSB = 1;
    localparam int CTL_POST_LSB = 5;
    localparam int CTL_TAP_SEL = 9;
    localparam int CTL_SYNC_LSB = 10;
    localparam int CTL_PCS_ENA = 12;
    localparam int CTL_CEV_ENA = 13;
    localparam int CTL_EXC_ENA = 14;
    localparam int CTL_PROF_LSB = 16;
    localparam logic [31:0] CTRL_WMASK = 32'h001f_7e1f;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CYCLE_RESET = 32'h0000_0000;
    localparam logic [3:0] POST_RESET = 4'h0;
    // Tap points of the cycle counter
    localparam int TAP_LO_BIT = 6;
    localparam int TAP_HI_BIT = 10;
    localparam int SYNC_BIT_A = 24;
    localparam int SYNC_BIT_B = 26;
    localparam int SYNC_BIT_C = 28;
    localparam logic [1:0] SYNC_OFF = 2'h0;
    localparam logic [1:0] SYNC_SEL_A = 2'h1;
    localparam logic [1:0] SYNC_SEL_B = 2'h2;
    // Profiling counters: extra, load-store, folded, exception, sleep
    localparam int PROF_NUM = 5;
    localparam int PROF_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EXC_NONE = 2'h0,
        EXC_ENTRY = 2'h1,
        EXC_EXIT = 2'h3,
        EXC_RESUME = 2'h2
    } exc_kind_t;

    typedef struct packed {
        logic tick;
        logic [PROF_NUM-1:0] overflow;
    } evt_flags_t;

    typedef struct packed {
        logic valid;
        exc_kind_t kind;
    } exc_pkt_t;
endpackage
`default_nettype wire

// ---- design/trace_cycle_profile_counters.sv ----
// Cycle counter, postscaler, profiling counters and exception trace with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module trace_cycle_profile_counters #(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core activity, one bit per cycle
    input wire logic multiCycleExtra,
    input wire logic fetchStall,
    input wire logic loadStoreExtra,
    input wire logic foldedInstr,
    input wire logic excOverheadCycle,
    input wire logic waitForInterruptSleep,
    input wire logic waitForEventSleep,
    input wire logic sleepAfterHandler,
    input wire logic excEntry,
    input wire logic excExit,
    input wire logic excReturn,
    // Enables held by the downstream trace unit
    input wire logic traceMasterEnable,
    input wire logic hwEventTxEnable,
    input wire logic timestampEnable,
    // Packet requests toward the trace unit
    output logic evtValid,
    output trace_counter_pkg::evt_flags_t evtFlags,
    output logic pcSampleValid,
    output trace_counter_pkg::exc_pkt_t excPkt,
    output logic sync_tap_select
);
    import trace_counter_pkg::*;

    initial begin
        if (ADDR_W < 6 || ADDR_W > 32) begin
            $error("ADDR_W must lie between 6 and 32");
        end
    end

    logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
    logic [ADDR_W-1:0] awAddr_ff;
    logic [31:0] wData_ff, rdata_ff, wMask_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] ctrl_ff, cycle_ff;
    logic [3:0] post_ff;
    logic tapPrev_ff, sync_tap_select_ff, evtValid_ff, pcValid_ff;
    evt_flags_t evtFlags_ff;
    exc_pkt_t excPkt_ff;
    logic [PROF_W-1:0] prof_ff [PROF_NUM];

    // Checks on the counter and packet behaviour share one clock and reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Write channel: address and data held separately, either may come first
    assign s_axi_awready = !awHeld_ff;
    assign s_axi_wready = !wHeld_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    wire wrFire = awHeld_ff && wHeld_ff && !bvalid_ff;
    wire [2:0] wrIdx = awAddr_ff[4:2];
    wire wrMapped = !(|awAddr_ff[ADDR_W-1:5]) && (wrIdx <= IDX_LAST);
    wire wrCtrl = wrFire && wrMapped && (wrIdx == IDX_CTRL);
    wire wrCycle = wrFire && wrMapped && (wrIdx == IDX_CYCLE);
    wire [31:0] nxt_ctrl = ((ctrl_ff & ~wMask_ff) | (wData_ff & wMask_ff)) & CTRL_WMASK;
    wire [31:0] nxt_cycWr = (cycle_ff & ~wMask_ff) | (wData_ff & wMask_ff);
    wire [31:0] strbMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    // Write handshake; the response waits for both halves
    always_ff @(posedge core_clk) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            awAddr_ff <= '0;
            wData_ff <= 32'h0000_0000;
            wMask_ff <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && !awHeld_ff) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end else if (wrFire) begin
                awHeld_ff <= 1'b0;
            end
            if (s_axi_wvalid && !wHeld_ff) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wMask_ff <= strbMask;
            end else if (wrFire) begin
                wHeld_ff <= 1'b0;
            end
            if (wrFire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Control fields
    wire ccEna = ctrl_ff[CTL_CC_ENA];
    wire [3:0] reload = ctrl_ff[CTL_RELOAD_LSB +: 4];
    wire pcsEna = ctrl_ff[CTL_PCS_ENA];
    wire cevEna = ctrl_ff[CTL_CEV_ENA];
    wire excEna = ctrl_ff[CTL_EXC_ENA];
    wire [PROF_NUM-1:0] profEna = ctrl_ff[CTL_PROF_LSB +: PROF_NUM];
    wire ccEnaRise = wrCtrl && nxt_ctrl[CTL_CC_ENA] && !ccEna;
    wire hwGate = traceMasterEnable && hwEventTxEnable && timestampEnable;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // counter write and count
    // A software write wins over the increment so a cleared value is exact
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cycle_ff <= CYCLE_RESET;
        end else if (wrCycle) begin
            cycle_ff <= nxt_cycWr;
        end else if (ccEna) begin
            cycle_ff <= cycle_ff + 32'h0000_0001;
        end
    end

    wire tapBit = ctrl_ff[CTL_TAP_SEL] ? cycle_ff[TAP_HI_BIT] : cycle_ff[TAP_LO_BIT];
    wire tapEdge = ccEna && (tapBit != tapPrev_ff);
    wire postZero = (post_ff == 4'h0);
    wire cycEvent = tapEdge && postZero && !pcsEna && cevEna;
    wire pcEvent = tapEdge && postZero && pcsEna;

    wire syncSel = (ctrl_ff[CTL_SYNC_LSB +: 2] == SYNC_SEL_A) ? cycle_ff[SYNC_BIT_A] :
                   (ctrl_ff[CTL_SYNC_LSB +: 2] == SYNC_SEL_B) ? cycle_ff[SYNC_BIT_B] :
                   (ctrl_ff[CTL_SYNC_LSB +: 2] == SYNC_OFF) ? 1'b0 : cycle_ff[SYNC_BIT_C];

    // postscaler reload and decrement
    // Tap history tracks even while idle so enabling does not fake a transition
    always_ff @(posedge core_clk) begin
        if (rst) begin
            post_ff <= POST_RESET;
            tapPrev_ff <= 1'b0;
            sync_tap_select_ff <= 1'b0;
        end else begin
            tapPrev_ff <= tapBit;
            sync_tap_select_ff <= syncSel;
            // The enabling write carries its own reload value, not the old one
            if (ccEnaRise) begin
                post_ff <= nxt_ctrl[CTL_RELOAD_LSB +: 4];
            end else if (tapEdge && postZero) begin
                post_ff <= reload;
            end else if (tapEdge) begin
                post_ff <= post_ff - 4'h1;
            end
        end
    end

    wire [PROF_NUM-1:0] profInc = {
        waitForInterruptSleep || waitForEventSleep || sleepAfterHandler,
        excOverheadCycle,
        foldedInstr,
        loadStoreExtra,
        multiCycleExtra || fetchStall
    };
    logic [PROF_NUM-1:0] profOvf;

    genvar gi;
    generate
        for (gi = 0; gi < PROF_NUM; gi++) begin : g_prof
            wire wrHit = wrFire && wrMapped && (wrIdx == IDX_PROF0 + 3'(gi));
            wire enaRise = wrCtrl && nxt_ctrl[CTL_PROF_LSB + gi] && !profEna[gi];
            assign profOvf[gi] = profEna[gi] && profInc[gi] && !wrHit && !enaRise &&
                                 (prof_ff[gi] == {PROF_W{1'b1}});
            // clear on enable, wrap, hold when off
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    prof_ff[gi] <= '0;
                end else if (enaRise) begin
                    prof_ff[gi] <= '0;
                end else if (wrHit) begin
                    prof_ff[gi] <= (prof_ff[gi] & ~wMask_ff[PROF_W-1:0]) |
                                   (wData_ff[PROF_W-1:0] & wMask_ff[PROF_W-1:0]);
                end else if (profEna[gi] && profInc[gi]) begin
                    prof_ff[gi] <= prof_ff[gi] + PROF_W'(1);
                end
            end
            prof_wrap_a: assert property (profOvf[gi] |=> prof_ff[gi] == '0)
                else $error("profiling counter did not wrap to zero");
            prof_clear_a: assert property (enaRise |=> prof_ff[gi] == '0)
                else $error("profiling counter not cleared on enable");
            prof_hold_a: assert property (!profEna[gi] && !wrHit && !enaRise
                |=> $stable(prof_ff[gi]))
                else $error("disabled profiling counter moved");
        end
    endgenerate

    // Exception kind: entry outranks exit, exit outranks return on a shared cycle
    wire [1:0] excKind = excEntry ? EXC_ENTRY : excExit ? EXC_EXIT :
                         excReturn ? EXC_RESUME : EXC_NONE;

    // packet emission behind the trace gate
    always_ff @(posedge core_clk) begin
        if (rst) begin
            evtValid_ff <= 1'b0;
            evtFlags_ff <= '0;
            pcValid_ff <= 1'b0;
            excPkt_ff <= '{valid: 1'b0, kind: EXC_NONE};
        end else begin
            evtValid_ff <= hwGate && (cycEvent || (|profOvf));
            evtFlags_ff <= '{tick: cycEvent, overflow: profOvf};
            pcValid_ff <= hwGate && pcEvent;
            excPkt_ff.valid <= hwGate && excEna && (excEntry || excExit || excReturn);
            excPkt_ff.kind <= exc_kind_t'(excKind);
        end
    end

    assign evtValid = evtValid_ff;
    assign evtFlags = evtFlags_ff;
    assign pcSampleValid = pcValid_ff;
    assign excPkt = excPkt_ff;
    assign sync_tap_select = sync_tap_select_ff;

    // Read channel: one-cycle answer, data captured at the address handshake
    wire [2:0] rdIdx = s_axi_araddr[4:2];
    wire rdMapped = !(|s_axi_araddr[ADDR_W-1:5]) && (rdIdx <= IDX_LAST);
    wire [31:0] ctrlRead = ctrl_ff | ({28'h0, post_ff} << CTL_POST_LSB);
    wire [31:0] profRead = (rdIdx >= IDX_PROF0) ?
                           {{(32-PROF_W){1'b0}}, prof_ff[rdIdx - IDX_PROF0]} : 32'h0000_0000;
    wire [31:0] rdMux = !rdMapped ? 32'h0000_0000 :
                        (rdIdx == IDX_CTRL) ? ctrlRead :
                        (rdIdx == IDX_CYCLE) ? cycle_ff : profRead;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rdMux;
            rresp_ff <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    post_reload_a: assert property (ccEnaRise
        |=> post_ff == $past(nxt_ctrl[CTL_RELOAD_LSB +: 4]))
        else $error("postscaler not loaded when counter enabled");
    post_dec_a: assert property (tapEdge && !postZero |=> post_ff == $past(post_ff) - 4'h1)
        else $error("postscaler did not decrement on tap transition");
    silent_reload_a: assert property (tapEdge && postZero && !pcsEna && !cevEna
        |=> post_ff == $past(reload) && !pcValid_ff && !evtFlags_ff.tick)
        else $error("silent reload emitted a packet or missed reload");
    tick_event_a: assert property (hwGate && cycEvent |=> evtValid_ff && evtFlags_ff.tick)
        else $error("cycle tick event missing");
    pc_sample_a: assert property (hwGate && tapEdge && postZero && pcsEna
        |=> pcValid_ff && !evtFlags_ff.tick && post_ff == $past(reload))
        else $error("PC sample packet missing or tick not suppressed");
    idle_hold_a: assert property (!ccEna && !wrCycle |=> $stable(cycle_ff) && !pcValid_ff)
        else $error("cycle counter ran while disabled");
    cycle_inc_a: assert property (ccEna && !wrCycle |=> cycle_ff == $past(cycle_ff) + 32'h1)
        else $error("cycle counter did not step by one");
    cycle_write_a: assert property (wrCycle |=> cycle_ff == $past(nxt_cycWr))
        else $error("cycle counter write lost");
    gate_block_a: assert property (!hwGate |=> !evtValid_ff && !pcValid_ff && !excPkt_ff.valid)
        else $error("packet passed a closed trace gate");
    ovf_event_a: assert property (hwGate && (|profOvf)
        |=> evtValid_ff && evtFlags_ff.overflow == $past(profOvf))
        else $error("overflow event flags wrong");
    exc_entry_a: assert property (hwGate && excEna && excEntry
        |=> excPkt_ff.valid && excPkt_ff.kind == EXC_ENTRY)
        else $error("exception entry packet missing");
    exc_leave_a: assert property (hwGate && excEna && !excEntry && (excExit || excReturn)
        |=> excPkt_ff.valid && excPkt_ff.kind != EXC_ENTRY)
        else $error("exception exit or return packet missing");
    sync_route_a: assert property (ctrl_ff[CTL_SYNC_LSB +: 2] == SYNC_SEL_B && !wrCtrl
        |=> sync_tap_select_ff == $past(cycle_ff[SYNC_BIT_B]))
        else $error("sync tap not routed from selected bit");

    tick_seen_c: cover property (evtValid_ff && evtFlags_ff.tick);
    pc_seen_c: cover property (pcValid_ff);
    ovf_seen_c: cover property (evtValid_ff && (|evtFlags_ff.overflow));
    exc_seen_c: cover property (excPkt_ff.valid && excPkt_ff.kind == EXC_RESUME);
endmodule // trace_cycle_profile_counters
`default_nettype wire

// ---- verif/tb_trace_cycle_profile_counters.sv ----
// Self-checking bench for the trace cycle and profiling counters
`default_nettype none
module tb_trace_cycle_profile_counters;
    timeunit 1ns;
    timeprecision 1ps;
    import trace_counter_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00, act = 8'h00;
    logic [31:0] wData = 32'h0, rData;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, evtValid, pcSampleValid, sync_tap_select;
    logic tmEna, txEna, timestamp_enable;
    logic [1:0] bResp, rResp;
    logic [2:0] exc = 3'h0, gateReq = 3'h7;
    logic [15:0] pktCount;
    logic [31:0] seed = 32'h89044b79;
    evt_flags_t evtFlags;
    exc_pkt_t excPkt;
    logic [34:0] respQ[$], pktQ[$];
    int errors = 0, n_tests = 0, cyc = 0, nPkt = 0, lastPkt = 0, cnt[5];

    // Free-running 125 MHz clock
    always #4 core_clk = ~core_clk;

    trace_cycle_profile_counters #(.ADDR_W(8)) dut (
        .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .multiCycleExtra(act[0]), .fetchStall(act[1]), .loadStoreExtra(act[2]),
        .foldedInstr(act[3]), .excOverheadCycle(act[4]), .waitForInterruptSleep(act[5]),
        .waitForEventSleep(act[6]), .sleepAfterHandler(act[7]), .excEntry(exc[2]),
        .excExit(exc[1]), .excReturn(exc[0]), .traceMasterEnable(tmEna),
        .hwEventTxEnable(txEna), .timestampEnable(timestamp_enable), .evtValid(evtValid),
        .evtFlags(evtFlags), .pcSampleValid(pcSampleValid), .excPkt(excPkt), .sync_tap_select(sync_tap_select));

    trace_unit_model partner (
        .core_clk(core_clk), .rst(rst), .gateReq(gateReq), .evtValid(evtValid),
        .pcSampleValid(pcSampleValid), .excValid(excPkt.valid), .traceMasterEnable(tmEna),
        .hwEventTxEnable(txEna), .timestampEnable(timestamp_enable), .pktCount(pktCount));

    task automatic report_and_stop();
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic giveUp();
        errors++;
        $display("Error at %0t: wait ran out", $time);
        report_and_stop();
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Oldest note of a kind; bit 34 marks a value checked elsewhere
    task automatic take(ref logic [34:0] q[$], input logic [34:0] seen);
        if (q.size() == 0) check(seen, 35'h7_ffff_ffff);
        else if (!q[0][34]) check(seen, q.pop_front());
        else void'(q.pop_front());
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic drain(input int bound);
        for (int i = 0; pktQ.size() != 0; i++) begin
            if (i == bound) giveUp();
            @(posedge core_clk);
        end
    endtask

    task automatic axiWrite(input logic [2:0] idx, input logic [31:0] d, input logic [1:0] rs);
        respQ.push_back({1'b0, rs, 32'h0});
        @(posedge core_clk);
        awAddr <= {3'h0, idx, 2'h0};
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        for (int i = 0; i <= 20; i++) begin
            @(posedge core_clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            if (bValid) break;
            if (i == 20) giveUp();
        end
        bReady <= 1'b0;
    endtask

    task automatic axiRead(input logic [2:0] idx, input logic [34:0] exp,
                           output logic [31:0] d, output int took);
        respQ.push_back(exp);
        @(posedge core_clk);
        arAddr <= {3'h0, idx, 2'h0};
        arValid <= 1'b1;
        rReady <= 1'b1;
        for (int i = 0; i <= 20; i++) begin
            @(posedge core_clk);
            if (arValid && arReady) begin
                took = cyc;
                arValid <= 1'b0;
            end
            if (rValid) begin
                d = rData;
                break;
            end
            if (i == 20) giveUp();
        end
        rReady <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        int t;
        axiRead(idx, {1'b0, RESP_OKAY, exp}, d, t);
    endtask

    // Random core activity for n cycles, tallied per profiling counter
    task automatic drive(input int n);
        logic [31:0] v;
        for (int i = 0; i < n; i++) begin
            v = rnd();
            @(posedge core_clk);
            act <= {v[7:2], v[1] & ~v[0], v[0]};
            cnt[0] += int'(v[0] | v[1]);
            cnt[1] += int'(v[2]);
            cnt[2] += int'(v[3]);
            cnt[3] += int'(v[4]);
            cnt[4] += int'(|v[7:5]);
        end
        @(posedge core_clk);
        act <= 8'h00;
    endtask

    task automatic pulse(input logic [2:0] e);
        @(posedge core_clk);
        exc <= e;
        @(posedge core_clk);
        exc <= 3'h0;
        ticks(3);
    endtask

    // Watcher: each response or packet is matched with the oldest note of its kind
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (!rst) begin
            if (rValid && rReady) take(respQ, {1'b0, rResp, rData});
            if (bValid && bReady) take(respQ, {1'b0, bResp, 32'h0});
            if (evtValid) take(pktQ, {29'h1, evtFlags});
            if (pcSampleValid) take(pktQ, 35'h2);
            if (excPkt.valid) take(pktQ, {33'h3, excPkt.kind});
            if (evtValid || pcSampleValid || excPkt.valid) lastPkt <= cyc;
        end
    end

    initial begin
        logic [31:0] d1, d2, r, w;
        int t1, t2, t0, rl, per, sel;
        exc_kind_t kd;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // reset contents, unmapped place, held value while disabled
        rd(IDX_CTRL, 32'h0);
        rd(IDX_CYCLE, 32'h0);
        axiRead(3'h7, {1'b0, RESP_SLVERR, 32'h0}, d1, t1);
        axiWrite(3'h7, 32'hffff_ffff, RESP_SLVERR);
        r = rnd();
        axiWrite(IDX_CYCLE, r, RESP_OKAY);
        ticks(5);
        rd(IDX_CYCLE, r);
        // one count per clock between two reads just below the wrap
        axiWrite(IDX_CYCLE, 32'hffff_fffa, RESP_OKAY);
        axiWrite(IDX_CTRL, 32'h1, RESP_OKAY);
        axiRead(IDX_CYCLE, 35'h4_0000_0000, d1, t1);
        axiRead(IDX_CYCLE, 35'h4_0000_0000, d2, t2);
        check(35'(d2 - d1), 35'(t2 - t1));
        for (int m = 0; m < 6; m++) begin
            rl = int'(rnd() % 3) + 1;
            per = (m[0] ? 1024 : 64) * (rl + 1);
            w = 32'h1 | (32'(rl) << CTL_RELOAD_LSB) | (32'(m[0]) << CTL_TAP_SEL);
            if (m >= 2) w |= 32'h1 << CTL_CEV_ENA;
            if (m >= 4) w |= 32'h1 << CTL_PCS_ENA;
            if (m >= 4) pktQ.push_back(35'h2);
            else if (m >= 2) pktQ.push_back({29'h1, 1'b1, 5'h0});
            axiWrite(IDX_CTRL, 32'h0, RESP_OKAY);
            axiWrite(IDX_CYCLE, 32'h0, RESP_OKAY);
            axiWrite(IDX_CTRL, w, RESP_OKAY);
            t0 = cyc;
            rd(IDX_CTRL, w | (32'(rl) << CTL_POST_LSB));
            drain(per + 64);
            if (m < 2) ticks(per + 64);
            else check(35'(lastPkt - t0 < per + 8 && lastPkt - t0 > per - 8), 35'h1);
            nPkt += int'(m >= 2);
        end
        axiWrite(IDX_CTRL, 32'h0, RESP_OKAY);
        for (int s = 0; s < 8; s++) begin
            sel = s % 4;
            r = rnd();
            r[22 + 2 * sel] = s < 4;
            axiWrite(IDX_CYCLE, r, RESP_OKAY);
            axiWrite(IDX_CTRL, 32'(sel) << CTL_SYNC_LSB, RESP_OKAY);
            ticks(3);
            check(35'(sync_tap_select), 35'(sel != 0 && s < 4));
        end
        // load, hold while disabled, clear on enable
        for (int k = 0; k < PROF_NUM; k++) axiWrite(IDX_PROF0 + 3'(k), 32'hffff_ff55, RESP_OKAY);
        drive(20);
        for (int k = 0; k < PROF_NUM; k++) rd(IDX_PROF0 + 3'(k), 32'h55);
        axiWrite(IDX_CTRL, 32'h1f << CTL_PROF_LSB, RESP_OKAY);
        for (int k = 0; k < PROF_NUM; k++) rd(IDX_PROF0 + 3'(k), 32'h0);
        cnt = '{default: 0};
        drive(40 + int'(rnd() % 40));
        for (int k = 0; k < PROF_NUM; k++) rd(IDX_PROF0 + 3'(k), 32'(cnt[k]));
        // all five wrap together into one packet
        for (int k = 0; k < PROF_NUM; k++) axiWrite(IDX_PROF0 + 3'(k), 32'hfe, RESP_OKAY);
        pktQ.push_back({29'h1, 1'b0, 5'h1f});
        @(posedge core_clk);
        act <= 8'hfd;
        ticks(2);
        act <= 8'h00;
        drain(10);
        nPkt++;
        for (int k = 0; k < PROF_NUM; k++) rd(IDX_PROF0 + 3'(k), 32'h0);
        // each exception kind, entry winning over the others
        axiWrite(IDX_CTRL, 32'h1 << CTL_EXC_ENA, RESP_OKAY);
        for (int e = 1; e < 8; e++) begin
            kd = e[2] ? EXC_ENTRY : (e[1] ? EXC_EXIT : EXC_RESUME);
            pktQ.push_back({33'h3, kd});
            pulse(3'(e));
            drain(10);
            nPkt++;
        end
        // any gate enable low drops the packet
        for (int g = 0; g < 3; g++) begin
            gateReq <= ~(3'h1 << g);
            ticks(2);
            pulse(3'h4);
        end
        gateReq <= 3'h7;
        axiWrite(IDX_CTRL, 32'h0, RESP_OKAY);
        pulse(3'h4);
        ticks(3);
        check(35'(pktCount), 35'(nPkt));
        check(35'(pktQ.size() + respQ.size()), 35'h0);
        report_and_stop();
    end
endmodule // tb_trace_cycle_profile_counters
`default_nettype wire

// ---- verif/trace_unit_model.sv ----
// Behavioural downstream trace unit: packet gate enables and a packet tally
`default_nettype none
module trace_unit_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [2:0] gateReq,
    input wire logic evtValid,
    input wire logic pcSampleValid,
    input wire logic excValid,
    output logic traceMasterEnable,
    output logic hwEventTxEnable,
    output logic timestampEnable,
    output logic [15:0] pktCount
);
    timeunit 1ns;
    timeprecision 1ps;
    // Enables follow the request a clock later, as a register write would
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {traceMasterEnable, hwEventTxEnable, timestampEnable} <= 3'h0;
            pktCount <= 16'h0000;
        end else begin
            {traceMasterEnable, hwEventTxEnable, timestampEnable} <= gateReq;
            pktCount <= pktCount + 16'(evtValid) + 16'(pcSampleValid) + 16'(excValid);
        end
    end
endmodule // trace_unit_model
`default_nettype wire
